// [hdl/fpp_programmer.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01 - prom holds 256 words of 4 bits, addressed by 8 bits, read when enabled
// R02 - unprogrammed bits read as one; programming flips single bits
// R03 - chip enable high forces all four data outputs to zero
// R04 - fuse exactly one output bit per operation, others left terminated
// R05 - stable address at least 100 ns before voltage pulse, held throughout
// R06 - programming voltage active at least 100 us, under 1 ms
// R07 - bit select asserted only once programming voltage is at full level
// R08 - bit select asserted at least 100 us
// R09 - fusing current starts at least 1 us after bit select
// R10 - fusing current rise at most 250 ns, on at least 100 us
// R11 - wait at least 1 us after current ends before releasing select
// R12 - release bit select first, then return programming voltage to zero
// R13 - sample outputs for verify no sooner than 100 ns after voltage off
// R14 - programming duty cycle kept at or below 15 percent
// R15 - compare verified output with intent, report bits that did not change
`include "fpp_regs.svh"
module fpp_programmer #(
   parameter int unsigned CUR_WIDTH_CYC = `FPP_CUR_WIDTH_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       readReq,
   input  wire logic       progReq,
   input  wire logic [7:0] reqAddr,
   input  wire logic [1:0] reqBit,
   output logic            busy,
   output logic            done,
   output logic            progFail,
   output logic      [3:0] readData,
   output logic      [7:0] promAddr,
   output logic            chipEnableN,
   output logic            fuseCurrent,
   output logic            programmingVoltage,
   output logic      [3:0] bitSelect,
   input  wire logic [3:0] promData
);
   // ==========================================================
   // timing constants
   localparam int unsigned SEL_CYC  = `FPP_RISE_CYC + `FPP_SEL_TO_CUR_CYC;
   localparam int unsigned VON_CYC  = `FPP_RISE_CYC + SEL_CYC + CUR_WIDTH_CYC
                                      + `FPP_CUR_TO_REL_CYC + 1;
   // rest so that on-time is at most 15 percent of the whole period
   localparam int unsigned REST_CYC = (VON_CYC * (100 - `FPP_DUTY_PCT) + `FPP_DUTY_PCT - 1)
                                      / `FPP_DUTY_PCT;

   function automatic fpp_pkg::fpp_cnt_t cyc(input int unsigned n);
      cyc = fpp_pkg::fpp_cnt_t'(n - 1);
   endfunction

   // states that drive the bit select; the voltage window is these plus rise and release
   function automatic logic selOn(input fpp_pkg::fpp_state_e s);
      selOn = s inside {fpp_pkg::FPP_SELECT, fpp_pkg::FPP_FUSE, fpp_pkg::FPP_HOLD};
   endfunction

   fpp_pkg::fpp_state_e state_q;
   fpp_pkg::fpp_cnt_t   cnt_q;
   logic                isProg_q;
   logic [1:0]          bit_q;
   logic [3:0]          dataSync;
   logic                expire;
   logic                take;
   logic                resultNow;

   assign expire = (cnt_q == 16'h0000);
   // a request is only taken from idle; anything else is ignored until the state is back in FPP_IDLE, a cycle before busy falls
   assign take = (state_q == fpp_pkg::FPP_IDLE) && (progReq || readReq);
   // the verify wait has run out: result and done land together
   assign resultNow = (state_q == fpp_pkg::FPP_SETTLE) && expire;

   fpp_sync uSync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .asyncIn (promData),
      .syncOut (dataSync)
   );

   // ==========================================================
   // request capture
   // address and bit are frozen at acceptance so the pins cannot move mid-pulse
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         isProg_q <= 1'b0;
         bit_q    <= 2'h0;
         promAddr <= 8'h00;
      end else if (take) begin
         promAddr <= reqAddr; // R01 R05
         bit_q    <= reqBit; // R04
         isProg_q <= progReq; // program wins if both
      end
   end

   // ==========================================================
   // sequencer
   // each state but IDLE and RELV waits for the counter to run out; its count is loaded as the state is entered
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= fpp_pkg::FPP_IDLE;
         cnt_q   <= 16'h0000;
      end else begin
         if (!expire) cnt_q <= cnt_q - 16'h0001;
         unique case (state_q)
            fpp_pkg::FPP_IDLE: begin
               if (take) begin
                  cnt_q   <= cyc(`FPP_ADDR_SETUP_CYC);
                  state_q <= progReq ? fpp_pkg::FPP_SETUP : fpp_pkg::FPP_SETTLE;
               end
            end
            // address settles on the pins before the voltage may start to rise
            fpp_pkg::FPP_SETUP: if (expire) begin // R05
               cnt_q   <= cyc(`FPP_RISE_CYC);
               state_q <= fpp_pkg::FPP_RISE;
            end
            // voltage ramping; the select waits for the full level, never before
            fpp_pkg::FPP_RISE: if (expire) begin // R07
               cnt_q   <= cyc(`FPP_SEL_TO_CUR_CYC);
               state_q <= fpp_pkg::FPP_SELECT;
            end
            // select alone on the pin before the current is allowed to start
            fpp_pkg::FPP_SELECT: if (expire) begin // R09
               cnt_q   <= cyc(CUR_WIDTH_CYC);
               state_q <= fpp_pkg::FPP_FUSE;
            end
            // fusing current on for its full width
            fpp_pkg::FPP_FUSE: if (expire) begin // R10
               cnt_q   <= cyc(`FPP_CUR_TO_REL_CYC);
               state_q <= fpp_pkg::FPP_HOLD;
            end
            // current off, select still held until the gap has passed
            fpp_pkg::FPP_HOLD: if (expire) begin // R11
               state_q <= fpp_pkg::FPP_RELV;
            end
            // one cycle with select already low and voltage still up
            fpp_pkg::FPP_RELV: begin // R12
               cnt_q   <= cyc(`FPP_VERIFY_CYC + 3);
               state_q <= fpp_pkg::FPP_SETTLE;
            end
            // the three extra cycles cover the voltage falling one clock after RELV and the two synchroniser stages
            fpp_pkg::FPP_SETTLE: if (expire) begin // R13
               cnt_q   <= isProg_q ? cyc(REST_CYC) : 16'h0000;
               state_q <= fpp_pkg::FPP_REST;
            end
            // off time keeps the pulse duty under its limit; reads skip it
            fpp_pkg::FPP_REST: if (expire) begin // R14
               state_q <= fpp_pkg::FPP_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // pin drive
   // every pin is registered so no decode glitch reaches the prom
   // enable stays low: the current has its own pin, and reads always see data
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         chipEnableN <= 1'b0;
      end else begin
         chipEnableN <= 1'b0; // R03 outputs valid only while enabled
      end
   end

   // voltage spans the release cycle as well, so the select always drops first
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         programmingVoltage <= 1'b0;
      end else begin
         programmingVoltage <= selOn(state_q) ||
                               (state_q inside {fpp_pkg::FPP_RISE, fpp_pkg::FPP_RELV}); // R06 R12
      end
   end

   // select minimum width is covered by the current width plus both gaps
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bitSelect <= 4'h0;
      end else begin
         bitSelect <= selOn(state_q) ? (4'h1 << bit_q) : 4'h0; // R04 R07 R08
      end
   end

   // current pulse follows the fuse state by one clock
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fuseCurrent <= 1'b0;
      end else begin
         fuseCurrent <= (state_q == fpp_pkg::FPP_FUSE); // R10 edge is one clock, under 250 ns
      end
   end

   // ==========================================================
   // verify and report
   // busy covers the cycle a request is seen, so a caller never sees a gap
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
      end else begin
         busy <= (state_q != fpp_pkg::FPP_IDLE) || progReq || readReq;
      end
   end

   // done is a one-cycle strobe at the end of the verify wait
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         done <= 1'b0;
      end else begin
         done <= resultNow; // R13
      end
   end

   // result words stand until the next operation finishes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         progFail <= 1'b0;
         readData <= `FPP_BLANK_WORD; // R02 blank word until a read lands
      end else if (resultNow) begin
         readData <= dataSync; // R13
         // a fused bit reads zero; a one left behind is a failure
         progFail <= isProg_q && dataSync[bit_q]; // R02 R15
      end
   end
endmodule // fpp_programmer
`default_nettype wire

// [hdl/fpp_regs.svh]
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH
// clock period in picoseconds (25 MHz)
`define FPP_CLK_PS            40000
// documented times, in their own units
`define FPP_ADDR_SETUP_NS     100
`define FPP_VOLT_WIDTH_US     100
`define FPP_VOLT_WIDTH_MAX_US 1000
`define FPP_SEL_TO_CUR_US     1
`define FPP_CUR_WIDTH_US      100
`define FPP_CUR_TO_REL_US     1
`define FPP_VERIFY_NS         100
`define FPP_DUTY_PCT          15
// derived cycle counts: least times round up
`define FPP_ADDR_SETUP_CYC ((`FPP_ADDR_SETUP_NS*1000+`FPP_CLK_PS-1)/`FPP_CLK_PS)
`define FPP_SEL_TO_CUR_CYC ((`FPP_SEL_TO_CUR_US*1000000+`FPP_CLK_PS-1)/`FPP_CLK_PS)
`define FPP_CUR_TO_REL_CYC ((`FPP_CUR_TO_REL_US*1000000+`FPP_CLK_PS-1)/`FPP_CLK_PS)
`define FPP_VERIFY_CYC     ((`FPP_VERIFY_NS*1000+`FPP_CLK_PS-1)/`FPP_CLK_PS)
`define FPP_CUR_WIDTH_CYC  ((`FPP_CUR_WIDTH_US*1000000+`FPP_CLK_PS-1)/`FPP_CLK_PS)
// voltage held up this long before the select is asserted (rise time margin)
`define FPP_RISE_CYC       25
`define FPP_BLANK_WORD     4'hF
`endif

// [hdl/fpp_pkg.sv]
package fpp_pkg;
   typedef logic [7:0]  fpp_addr_t;
   typedef logic [3:0]  fpp_word_t;
   typedef logic [15:0] fpp_cnt_t;
   typedef enum logic [8:0] {
      FPP_IDLE   = 9'h001,
      FPP_SETUP  = 9'h002,
      FPP_RISE   = 9'h004,
      FPP_SELECT = 9'h008,
      FPP_FUSE   = 9'h010,
      FPP_HOLD   = 9'h020,
      FPP_RELV   = 9'h040,
      FPP_SETTLE = 9'h080,
      FPP_REST   = 9'h100
   } fpp_state_e;
endpackage

// [hdl/fpp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for the prom data pins
module fpp_sync (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [3:0] asyncIn,
   output logic      [3:0] syncOut
);
   logic [3:0] meta_q;
   // first stage read only by the second
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_q  <= 4'h0;
         syncOut <= 4'h0;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule // fpp_sync
`default_nettype wire

// [sim/fpp_programmer_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// fuse sequence checks on the controller pins
module fpp_programmer_assertions #(
   parameter int unsigned CUR_WIDTH_CYC = 10
) (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       done,
   input wire logic [7:0] promAddr,
   input wire logic       fuseCurrent,
   input wire logic       programmingVoltage,
   input wire logic [3:0] bitSelect
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [15:0] curCnt_q;
   // counts current pulse length; a repetition cannot hold the full width
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) curCnt_q <= 16'h0000;
      else curCnt_q <= fuseCurrent ? curCnt_q + 16'h0001 : 16'h0000;
   end
   sequence s_sel_held;
      (bitSelect != 4'h0) [*8];
   endsequence
   a_select_one_hot: assert property ($onehot0(bitSelect)) else $error("two bits");
   a_addr_setup: assert property ($rose(programmingVoltage) |-> $past(promAddr, 3) == promAddr)
      else $error("address setup");
   a_addr_held: assert property (programmingVoltage |-> $stable(promAddr)) else $error("addr");
   a_select_needs_volt: assert property (|bitSelect |-> programmingVoltage) else $error("sel");
   a_select_lead: assert property ($rose(fuseCurrent) |-> $past(bitSelect, 25) != 4'h0)
      else $error("select lead");
   a_current_width: assert property ($fell(fuseCurrent) |-> curCnt_q >= CUR_WIDTH_CYC)
      else $error("current width");
   a_select_tail: assert property ($fell(fuseCurrent) |-> s_sel_held) else $error("tail");
   // the select may only drop a full microsecond after the current has gone
   a_release_gap: assert property ($fell(|bitSelect) |-> $past(fuseCurrent, 25) == 1'b0)
      else $error("select released early");
   a_select_drops_first: assert property ($fell(programmingVoltage) |-> $past(bitSelect) == 4'h0)
      else $error("release order");
   a_verify_delay: assert property ($fell(programmingVoltage) |-> !done [*3]) else $error("early");
endmodule // fpp_programmer_assertions
bind fpp_programmer fpp_programmer_assertions #(.CUR_WIDTH_CYC(CUR_WIDTH_CYC)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .done(done), .promAddr(promAddr), .fuseCurrent(fuseCurrent),
   .programmingVoltage(programmingVoltage), .bitSelect(bitSelect));
`default_nettype wire

// [sim/fpp_prom_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// behavioural fuse prom, 256 words of 4 bits
module fpp_prom_model (
   input  wire logic [7:0] promAddr,
   input  wire logic       chipEnableN,
   input  wire logic       fuseCurrent,
   input  wire logic       programmingVoltage,
   input  wire logic [3:0] bitSelect,
   input  wire logic       stuckFuse,
   output logic      [3:0] promData
);
   logic [3:0] mem [256];
   // blank part reads all ones
   initial foreach (mem[i]) mem[i] = 4'hF;
   // a fuse blows only with voltage up and one bit picked; stuckFuse models a bad fuse
   always @(posedge fuseCurrent) begin
      if (programmingVoltage && $onehot(bitSelect) && !stuckFuse)
         mem[promAddr] = mem[promAddr] & ~bitSelect;
   end
   // disabled part pulls every output low
   assign promData = chipEnableN ? 4'h0 : mem[promAddr];
endmodule // fpp_prom_model
`default_nettype wire

// [sim/tb_fpp_programmer.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench for the fuse prom controller
module tb_fpp_programmer;
   typedef struct {logic p; logic [7:0] a; logic [1:0] b; logic [3:0] d;} fpp_row_s;
   logic       clk_sys, rst, readReq, progReq, stuckFuse, busy, done, progFail;
   logic       chipEnableN, fuseCurrent, programmingVoltage;
   logic [7:0] reqAddr, promAddr;
   logic [1:0] reqBit;
   logic [3:0] readData, bitSelect, promData;
   int         failures, cmp_count;
   fpp_row_s   rows [7] = '{'{0, 8'h00, 2'h0, 4'hF}, '{1, 8'h00, 2'h0, 4'hE},
      '{1, 8'h00, 2'h3, 4'h6}, '{1, 8'hFF, 2'h1, 4'hD}, '{0, 8'h00, 2'h0, 4'h6},
      '{0, 8'hFF, 2'h0, 4'hD}, '{0, 8'h80, 2'h0, 4'hF}};
   fpp_programmer #(.CUR_WIDTH_CYC(10)) dut (.clk_sys(clk_sys), .rst(rst), .readReq(readReq),
      .progReq(progReq), .reqAddr(reqAddr), .reqBit(reqBit), .busy(busy), .done(done),
      .progFail(progFail), .readData(readData), .promAddr(promAddr), .chipEnableN(chipEnableN),
      .fuseCurrent(fuseCurrent), .programmingVoltage(programmingVoltage),
      .bitSelect(bitSelect), .promData(promData));
   fpp_prom_model u_prom (.promAddr(promAddr), .chipEnableN(chipEnableN),
      .fuseCurrent(fuseCurrent), .programmingVoltage(programmingVoltage),
      .bitSelect(bitSelect), .stuckFuse(stuckFuse), .promData(promData));
   task chk(input logic [3:0] got, input logic [3:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one request, then bounded waits for done and idle
   task op(input logic p, input logic [7:0] a, input logic [1:0] b, input int hold);
      int n;
      progReq = p;
      readReq = !p;
      reqAddr = a;
      reqBit = b;
      repeat (hold) @(posedge clk_sys);
      #2 progReq = 0;
      readReq = 0;
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge clk_sys);
         #2 n++;
      end
      chk({3'h0, done}, 4'h1);
      while (busy !== 1'b0 && n < 9000) begin
         @(posedge clk_sys);
         #2 n++;
      end
      chk({3'h0, busy}, 4'h0);
   endtask
   task test_done;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // free running system clock
   initial begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   // hang guard, far beyond the expected run
   initial begin
      #(60000 * 40);
      failures++;
      $display("ERROR %0t watchdog expired", $time);
      test_done;
   end
   // table rows first, then refusal, bad fuse and reset cases
   initial begin
      {rst, readReq, progReq, reqAddr, reqBit, stuckFuse, failures, cmp_count} = '0;
      rst = 1;
      repeat (8) @(posedge clk_sys);
      #2 rst = 0;
      chk(bitSelect, 4'h0);
      foreach (rows[i]) begin
         op(rows[i].p, rows[i].a, rows[i].b, 1);
         chk(readData, rows[i].d);
         if (rows[i].p) chk({3'h0, progFail}, 4'h0);
         $display("row %0d finished", i);
      end
      op(1, 8'h40, 2'h2, 12);
      op(0, 8'h40, 2'h0, 1);
      chk(readData, 4'hB);
      stuckFuse = 1;
      op(1, 8'h80, 2'h2, 1);
      chk({3'h0, progFail}, 4'h1);
      stuckFuse = 0;
      $display("refusal and bad fuse finished");
      progReq = 1;
      readReq = 1;
      reqAddr = 8'h20;
      reqBit = 2'h1;
      repeat (40) @(posedge clk_sys);
      #2 chk(bitSelect, 4'h2);
      rst = 1;
      progReq = 0;
      readReq = 0;
      #40 chk({programmingVoltage, fuseCurrent, chipEnableN, 1'b0}, 4'h0);
      chk(bitSelect, 4'h0);
      rst = 0;
      op(0, 8'h20, 2'h0, 1);
      chk(readData, 4'hF);
      $display("abort finished");
      test_done;
   end
endmodule // tb_fpp_programmer
`default_nettype wire
